/* bit_branch_pkg.sv */
// Shared constants and types for the four-instruction execute block.
// Assumes a fetch path that follows pc and a byte-wide register file.
// Functional notes
// RQ1: Toggle op inverts only addressed register bit
// RQ2: Bank flag clear selects fast bank
// RQ3: Overflow branch taken only when overflow set
// RQ4: Taken branch adds doubled signed offset
// RQ5: Target is instruction address plus two plus offset
// RQ6: Taken branch two cycles, untaken branch one
// RQ7: Two-word jump loads twenty-bit target at bit one
// RQ8: Jump reaches the whole program space
// RQ9: Jump always two cycles, second is idle
// RQ10: Increment op adds one to selected register
// RQ11: Destination flag picks accumulator or source register
// RQ12: Increment updates carry, digit carry, negative, overflow, zero
// RQ13: Toggle, increment: one cycle, read Q2, write Q4; accumulator and flags load at the end of Q3
package bit_branch_pkg;

    // Widths
    localparam int PC_W = 21;
    localparam int RF_ADDR_W = 12;

    // Opcode fields and their values
    localparam logic [3:0] TOGGLE_CODE = 4'h7;
    localparam logic [7:0] BRANCH_OVERFLOW_CODE = 8'he4;
    localparam logic [7:0] JUMP_FIRST_CODE = 8'hef;
    localparam logic [3:0] JUMP_SECOND_CODE = 4'hf;
    localparam logic [5:0] INC_CODE = 6'h0a;

    // Operand field positions
    localparam int BANK_FLAG_BIT = 8;
    localparam int DEST_FLAG_BIT = 9;
    localparam int BIT_IDX_LO = 9;

    // Fast bank split: low half maps to one bank, high half to another
    localparam logic [7:0] FAST_SPLIT = 8'h80;
    localparam logic [3:0] FAST_LO_BANK = 4'h0;
    localparam logic [3:0] FAST_HI_BANK = 4'hf;

    // Counter step and data corner values
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ALL = 8'hff;
    localparam logic [7:0] BYTE_MAXPOS = 8'h7f;
    localparam logic [3:0] NIB_ALL = 4'hf;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    // Four clock phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_t;

    // Decoded operation of the current cycle
    typedef enum logic [5:0] {
        OP_NOP = 6'h01,
        OP_TOGGLE = 6'h02,
        OP_BRANCH = 6'h04,
        OP_JUMP1 = 6'h08,
        OP_JUMP2 = 6'h10,
        OP_INC = 6'h20
    } op_t;

    // Register file access strobe with address and data
    typedef struct packed {
        logic en;
        logic [RF_ADDR_W-1:0] addr;
        logic [7:0] data;
    } rf_req_t;

    // Arithmetic status flags
    typedef struct packed {
        logic negative;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } status_t;

    localparam status_t STATUS_RESET = 5'h00;
    localparam rf_req_t RF_IDLE = 21'h000000;

endpackage

/* bit_branch_increment_exec.sv */
// Decode and execute for bit toggle, overflow branch, absolute jump and
// increment. Assumes the fetch path presents the word at pc during Q1
// and the register file answers a read within the Q2 clock.
`timescale 1ns/10ps
`default_nettype none

module bit_branch_increment_exec (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] rf_rd_data,
    output logic [bit_branch_pkg::PC_W-1:0] pc,
    output logic rf_rd_en,
    output logic [bit_branch_pkg::RF_ADDR_W-1:0] rf_rd_addr,
    output bit_branch_pkg::rf_req_t rf_wr,
    output logic [7:0] acc,
    output bit_branch_pkg::status_t status,
    output bit_branch_pkg::phase_t phase
);

    // Operation decode of a freshly fetched word
    function automatic bit_branch_pkg::op_t op_decode(
        input logic [15:0] w
    );
        if (w[15:12] == bit_branch_pkg::TOGGLE_CODE) begin
            op_decode = bit_branch_pkg::OP_TOGGLE;
        end else if (w[15:8] == bit_branch_pkg::BRANCH_OVERFLOW_CODE) begin
            op_decode = bit_branch_pkg::OP_BRANCH;
        end else if (w[15:8] == bit_branch_pkg::JUMP_FIRST_CODE) begin
            op_decode = bit_branch_pkg::OP_JUMP1;
        end else if (w[15:10] == bit_branch_pkg::INC_CODE) begin
            op_decode = bit_branch_pkg::OP_INC;
        end else begin
            // Anything else is executed as a plain one-cycle no-op
            op_decode = bit_branch_pkg::OP_NOP;
        end
    endfunction

    // Banked register address from flag, address byte and bank select
    function automatic logic [bit_branch_pkg::RF_ADDR_W-1:0] bank_addr(
        input logic a,
        input logic [7:0] f,
        input logic [3:0] bsel
    );
        logic [3:0] bank;
        bank = bsel;
        if (!a) begin
            // Fast bank ignores the bank select value [RQ2]
            bank = (f < bit_branch_pkg::FAST_SPLIT) ?
                bit_branch_pkg::FAST_LO_BANK : bit_branch_pkg::FAST_HI_BANK;
        end
        bank_addr = {bank, f};
    endfunction

    // Phase state
    bit_branch_pkg::phase_t phase_r, phase_nxt;

    // Datapath state
    logic [bit_branch_pkg::PC_W-1:0] pc_r, pc_nxt; // Address of current word
    logic [15:0] ir_r, ir_nxt; // Latched instruction word
    bit_branch_pkg::op_t op_r, op_nxt; // Operation of this cycle
    logic [bit_branch_pkg::RF_ADDR_W-1:0] addr_r, addr_nxt; // Banked address
    logic rd_en_r, rd_en_nxt; // Read strobe, high through Q2
    logic [7:0] data_r, data_nxt; // Operand read in Q2
    bit_branch_pkg::rf_req_t wr_r, wr_nxt; // Write strobe, high through Q4
    logic [7:0] acc_r, acc_nxt; // Accumulator
    bit_branch_pkg::status_t status_r, status_nxt; // Flags
    logic flush_r, flush_nxt; // Current cycle is the idle cycle of a branch
    logic jump_pend_r, jump_pend_nxt; // Next word is a jump's second word
    logic [7:0] jump_lo_r, jump_lo_nxt; // Low target byte of a pending jump

    // Helper terms for the process phase
    logic [7:0] inc_val;
    logic [7:0] bit_mask;
    logic [bit_branch_pkg::PC_W-1:0] branch_target;

    assign inc_val = data_r + bit_branch_pkg::BYTE_ONE;
    assign bit_mask = bit_branch_pkg::BYTE_ONE <<
        ir_r[bit_branch_pkg::BIT_IDX_LO +: 3];
    // Counter not yet advanced, so two is added; offset is signed and doubled
    assign branch_target = pc_r + bit_branch_pkg::PC_STEP +
        {{12{ir_r[7]}}, ir_r[7:0], 1'b0}; // [RQ4] [RQ5]

    // Phase sequencer: four clocks make one instruction cycle
    always_comb begin
        case (phase_r)
            bit_branch_pkg::PH_Q1: phase_nxt = bit_branch_pkg::PH_Q2;
            bit_branch_pkg::PH_Q2: phase_nxt = bit_branch_pkg::PH_Q3;
            bit_branch_pkg::PH_Q3: phase_nxt = bit_branch_pkg::PH_Q4;
            bit_branch_pkg::PH_Q4: phase_nxt = bit_branch_pkg::PH_Q1;
            default: phase_nxt = bit_branch_pkg::PH_Q1;
        endcase
    end

    // Phase register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_r <= bit_branch_pkg::PH_Q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Next values of the datapath, stepped by phase
    always_comb begin
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        rd_en_nxt = rd_en_r;
        data_nxt = data_r;
        wr_nxt = wr_r;
        acc_nxt = acc_r;
        status_nxt = status_r;
        flush_nxt = flush_r;
        jump_pend_nxt = jump_pend_r;
        jump_lo_nxt = jump_lo_r;
        case (phase_r)
            // Q1: decode the fetched word
            bit_branch_pkg::PH_Q1: begin
                ir_nxt = instr_word;
                addr_nxt = bank_addr(instr_word[bit_branch_pkg::BANK_FLAG_BIT],
                    instr_word[7:0], bank_select_register); // [RQ2]
                if (flush_r) begin
                    // Word fetched behind a taken branch is discarded [RQ6]
                    op_nxt = bit_branch_pkg::OP_NOP;
                end else if (jump_pend_r) begin
                    // Second jump word; a stray word is only skipped [RQ7]
                    op_nxt = (instr_word[15:12] ==
                        bit_branch_pkg::JUMP_SECOND_CODE) ?
                        bit_branch_pkg::OP_JUMP2 : bit_branch_pkg::OP_NOP;
                end else begin
                    op_nxt = op_decode(instr_word); // [RQ1] [RQ3] [RQ10]
                end
                // Only the register operations read in Q2 [RQ13]
                rd_en_nxt = !flush_r && !jump_pend_r &&
                    (op_decode(instr_word) == bit_branch_pkg::OP_TOGGLE ||
                    op_decode(instr_word) == bit_branch_pkg::OP_INC);
            end
            // Q2: capture operand at the end of the read strobe
            bit_branch_pkg::PH_Q2: begin
                rd_en_nxt = 1'b0;
                data_nxt = rf_rd_data; // [RQ13]
            end
            // Q3: process data and arm the Q4 write
            bit_branch_pkg::PH_Q3: begin
                case (op_r)
                    bit_branch_pkg::OP_TOGGLE: begin
                        // Only the indexed bit flips; flags untouched [RQ1]
                        wr_nxt = {1'b1, addr_r, data_r ^ bit_mask};
                    end
                    bit_branch_pkg::OP_INC: begin
                        if (ir_r[bit_branch_pkg::DEST_FLAG_BIT]) begin
                            wr_nxt = {1'b1, addr_r, inc_val}; // [RQ10] [RQ11]
                        end else begin
                            acc_nxt = inc_val; // [RQ11]
                        end
                        // Wrap of all-ones sets zero and both carries [RQ12]
                        status_nxt.carry = (data_r == bit_branch_pkg::BYTE_ALL);
                        status_nxt.digit_carry_flag =
                            (data_r[3:0] == bit_branch_pkg::NIB_ALL);
                        status_nxt.zero =
                            (inc_val == bit_branch_pkg::BYTE_ZERO);
                        status_nxt.negative = inc_val[7];
                        status_nxt.overflow_flag =
                            (data_r == bit_branch_pkg::BYTE_MAXPOS);
                    end
                    default: begin
                        // Branch and jump change no flags [RQ3]
                        wr_nxt = bit_branch_pkg::RF_IDLE;
                    end
                endcase
            end
            // Q4: write strobe ends, counter updates
            bit_branch_pkg::PH_Q4: begin
                wr_nxt = bit_branch_pkg::RF_IDLE;
                pc_nxt = pc_r + bit_branch_pkg::PC_STEP;
                case (op_r)
                    bit_branch_pkg::OP_BRANCH: begin
                        if (status_r.overflow_flag) begin
                            // Taken: load target and idle one cycle [RQ3] [RQ6]
                            pc_nxt = branch_target; // [RQ4] [RQ5]
                            flush_nxt = 1'b1;
                        end
                    end
                    bit_branch_pkg::OP_JUMP1: begin
                        // Keep low byte, then fetch the second word [RQ7]
                        jump_lo_nxt = ir_r[7:0];
                        jump_pend_nxt = 1'b1;
                    end
                    bit_branch_pkg::OP_JUMP2: begin
                        // Idle cycle loads the full 20-bit target [RQ8] [RQ9]
                        pc_nxt = {ir_r[11:0], jump_lo_r, 1'b0}; // [RQ7]
                        jump_pend_nxt = 1'b0;
                    end
                    default: begin
                        if (flush_r) begin
                            // Counter already holds the branch target [RQ6]
                            pc_nxt = pc_r;
                        end
                        jump_pend_nxt = 1'b0;
                    end
                endcase
                if (op_r != bit_branch_pkg::OP_BRANCH) begin
                    flush_nxt = 1'b0;
                end
            end
            default: begin
                wr_nxt = bit_branch_pkg::RF_IDLE;
            end
        endcase
    end

    // Datapath registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc_r <= bit_branch_pkg::PC_RESET;
            ir_r <= 16'h0000;
            op_r <= bit_branch_pkg::OP_NOP;
            addr_r <= 12'h000;
            rd_en_r <= 1'b0;
            data_r <= bit_branch_pkg::BYTE_ZERO;
            wr_r <= bit_branch_pkg::RF_IDLE;
            acc_r <= bit_branch_pkg::BYTE_ZERO;
            status_r <= bit_branch_pkg::STATUS_RESET;
            flush_r <= 1'b0;
            jump_pend_r <= 1'b0;
            jump_lo_r <= bit_branch_pkg::BYTE_ZERO;
        end else begin
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            rd_en_r <= rd_en_nxt;
            data_r <= data_nxt;
            wr_r <= wr_nxt;
            acc_r <= acc_nxt;
            status_r <= status_nxt;
            flush_r <= flush_nxt;
            jump_pend_r <= jump_pend_nxt;
            jump_lo_r <= jump_lo_nxt;
        end
    end

    // Outputs straight from flops
    assign pc = pc_r;
    assign rf_rd_en = rd_en_r;
    assign rf_rd_addr = addr_r;
    assign rf_wr = wr_r;
    assign acc = acc_r;
    assign status = status_r;
    assign phase = phase_r;

endmodule

`default_nettype wire

/* bit_branch_increment_exec_asserts.sv */
// Checker for the four-instruction execute block.
// Sees only the block's ports; bound in at the foot of this file.
`timescale 1ns/10ps
`default_nettype none

module bit_branch_increment_exec_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] rf_rd_data,
    input wire logic [20:0] pc,
    input wire logic rf_rd_en,
    input wire logic [11:0] rf_rd_addr,
    input wire bit_branch_pkg::rf_req_t rf_wr,
    input wire logic [7:0] acc,
    input wire bit_branch_pkg::status_t status,
    input wire bit_branch_pkg::phase_t phase
);
    localparam bit_branch_pkg::phase_t Q1 = bit_branch_pkg::PH_Q1;
    localparam bit_branch_pkg::phase_t Q2 = bit_branch_pkg::PH_Q2;
    localparam bit_branch_pkg::phase_t Q3 = bit_branch_pkg::PH_Q3;
    localparam bit_branch_pkg::phase_t Q4 = bit_branch_pkg::PH_Q4;
    logic [15:0] word_r; // Word taken at the end of Q1
    logic [3:0] bsel_r; // Bank select taken with it
    logic [7:0] rd_r, jlo_r, inc_v; // Byte read, jump low byte, sum
    logic skip_r, j1_r; // Idle cycle, jump second word due
    logic is_branch, is_jf, is_inc;

    // Branch and jump words are live only outside idle and jump-second cycles
    assign is_branch = !skip_r && !j1_r && word_r[15:8] == 8'he4;
    assign is_jf = !skip_r && !j1_r && word_r[15:8] == 8'hef;
    assign is_inc = word_r[15:10] == bit_branch_pkg::INC_CODE;
    assign inc_v = rd_r + 8'h01;

    // Shadow of the decode so properties can name the running word
    always_ff @(posedge ref_clk) begin
        if (phase == Q1) begin
            word_r <= instr_word;
            bsel_r <= bank_select_register;
        end
        if (rf_rd_en) begin
            rd_r <= rf_rd_data;
        end
        if (phase == Q4 && is_jf) begin
            jlo_r <= word_r[7:0];
        end
        if (rst) begin
            skip_r <= 1'b0;
            j1_r <= 1'b0;
        end else if (phase == Q4) begin
            skip_r <= is_branch && status.overflow_flag;
            j1_r <= is_jf;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_cycle;
        phase == Q2 ##1 phase == Q3 ##1 phase == Q4 ##1 phase == Q1;
    endsequence
    // The edge that drops reset still sees Q1 twice, so skip it
    property p_phase;
        !rst && phase == Q1 |=> s_cycle;
    endproperty
    a_phase: assert property (p_phase) else $error("phase order");
    property p_slots;
        rf_rd_en || rf_wr.en |-> phase == (rf_rd_en ? Q2 : Q4);
    endproperty
    a_slots: assert property (p_slots) else $error("strobe phase");
    property p_pc_hold;
        phase != Q4 || skip_r |=> $stable(pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
    property p_toggle;
        rf_rd_en && word_r[15:12] == 4'h7 |-> ##2 rf_wr.en
            && rf_wr.addr == rf_rd_addr
            && rf_wr.data == (rd_r ^ (8'h01 << word_r[11:9]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle");
    property p_bank;
        rf_rd_en |-> rf_rd_addr
            == {word_r[8] ? bsel_r : {4{word_r[7]}}, word_r[7:0]};
    endproperty
    a_bank: assert property (p_bank) else $error("bank select");
    property p_inc;
        rf_rd_en && is_inc |-> ##2 (word_r[9] ? rf_wr.en
            && rf_wr.data == inc_v : !rf_wr.en && acc == inc_v);
    endproperty
    a_inc: assert property (p_inc) else $error("increment");
    property p_flags;
        rf_rd_en && is_inc |-> ##2 status == {inc_v[7], rd_r == 8'h7f,
            inc_v == 8'h00, &rd_r[3:0], &rd_r};
    endproperty
    a_flags: assert property (p_flags) else $error("inc flags");
    property p_status_hold;
        $changed(status) |-> $past(rst) || $past(phase) == Q3 && is_inc;
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("flags");
    property p_branch;
        phase == Q4 && is_branch |=> pc == $past(pc) + 21'h000002
            + ($past(status.overflow_flag)
            ? {{12{word_r[7]}}, word_r[7:0], 1'b0} : 21'h000000);
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch");
    property p_idle;
        skip_r || j1_r |-> !rf_rd_en && !rf_wr.en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle access");
    property p_jump;
        phase == Q4 && j1_r |=> pc == (word_r[15:12] == 4'hf
            ? {word_r[11:0], jlo_r, 1'b0} : $past(pc) + 21'h000002);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target");
endmodule

bind bit_branch_increment_exec bit_branch_increment_exec_checker i_chk (
    .ref_clk, .rst, .instr_word, .bank_select_register, .rf_rd_data,
    .pc, .rf_rd_en, .rf_rd_addr, .rf_wr, .acc, .status, .phase);
`default_nettype wire

/* bit_branch_fetch_model.sv */
// Program store and register file that face the execute block.
// Assumes pc counts bytes; a word sits at pc bits 20..1.
`timescale 1ns/10ps
`default_nettype none

module bit_branch_fetch_model (
    input wire logic ref_clk,
    input wire logic [20:0] pc,
    input wire logic rf_rd_en,
    input wire logic [11:0] rf_rd_addr,
    input wire bit_branch_pkg::rf_req_t rf_wr,
    output logic [15:0] instr_word,
    output logic [7:0] rf_rd_data
);
    logic [15:0] prog [int]; // Sparse store, empty places read as zero
    logic [7:0] regs [4096]; // Bank in the upper nibble of the index

    // Known values from time zero
    initial begin
        instr_word = 16'h0000;
        rf_rd_data = 8'h00;
    end

    // Answer mid-period; an unselected read bus flips every cycle so a
    // stale byte never passes for a real answer
    always @(negedge ref_clk) begin
        instr_word <= prog.exists(int'(pc[20:1]))
            ? prog[int'(pc[20:1])] : 16'h0000;
        rf_rd_data <= rf_rd_en ? regs[rf_rd_addr] : ~rf_rd_data;
    end

    // Write lands at the edge ending Q4
    always @(posedge ref_clk) begin
        if (rf_wr.en) begin
            regs[rf_wr.addr] <= rf_wr.data;
        end
    end
endmodule
`default_nettype wire

/* bit_branch_increment_exec_bench.sv */
// Self-checking bench for the four-instruction execute block.
// Assumes the fetch model serves program words and register bytes.
`timescale 1ns/10ps
`default_nettype none

module bit_branch_increment_exec_bench;
    logic ref_clk, rst, rf_rd_en;
    logic [3:0] bank_select_register;
    logic [15:0] instr_word;
    logic [7:0] rf_rd_data, acc;
    logic [20:0] pc;
    logic [11:0] rf_rd_addr;
    bit_branch_pkg::rf_req_t rf_wr;
    bit_branch_pkg::status_t status;
    bit_branch_pkg::phase_t phase;
    int errors, check_count;

    bit_branch_increment_exec i_dut (.ref_clk, .rst, .instr_word,
        .bank_select_register, .rf_rd_data, .pc, .rf_rd_en, .rf_rd_addr,
        .rf_wr, .acc, .status, .phase);
    bit_branch_fetch_model m (.ref_clk, .pc, .rf_rd_en, .rf_rd_addr,
        .rf_wr, .instr_word, .rf_rd_data);

    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Three-cycle reset; the first period after it is Q1
    task automatic start(input logic [3:0] b);
        @(posedge ref_clk);
        rst <= 1'b1;
        bank_select_register <= b;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        m.prog.delete();
    endtask

    // Whole instruction cycles, then let the edge settle
    task automatic cyc(input int n);
        repeat (4 * n) @(posedge ref_clk);
        #1;
    endtask

    task automatic toggle_test;
        start(4'h3);
        m.regs[12'h005] = 8'h75;
        m.regs[12'h305] = 8'h11;
        m.regs[12'hf90] = 8'h3c;
        m.prog[0] = 16'h7805; // Bit 4, fast bank
        m.prog[1] = 16'h7f05; // Bit 7, bank select
        m.prog[2] = 16'h7090; // Bit 0, upper fast half
        cyc(3);
        check(m.regs[12'h005], 21'h65);
        check(m.regs[12'h305], 21'h91);
        check(m.regs[12'hf90], 21'h3d);
        check(pc, 21'h6);
    endtask

    task automatic inc_test;
        start(4'h2);
        m.regs[12'h010] = 8'hff;
        m.regs[12'h220] = 8'h7f;
        m.prog[0] = 16'h2a10; // Back to register, wraps
        m.prog[1] = 16'h2920; // To accumulator, bank select
        cyc(1);
        check(m.regs[12'h010], 21'h0);
        check(status, 21'h07);
        cyc(1);
        check(acc, 21'h80);
        check(m.regs[12'h220], 21'h7f);
        check(status, 21'h1a);
    endtask

    task automatic branch_test;
        start(4'h0);
        m.regs[12'h020] = 8'h7f;
        m.regs[12'h021] = 8'h00;
        m.prog[0] = 16'h2820; // Sets overflow
        m.prog[1] = 16'he47f; // Largest forward step
        m.prog[8'h81] = 16'he480; // Largest backward step
        m.prog[2] = 16'h2821; // Clears overflow
        m.prog[3] = 16'he410; // Not taken
        cyc(2);
        check(pc, 21'h102);
        check(status, 21'h1a);
        cyc(1);
        check(pc, 21'h102);
        cyc(2);
        check(pc, 21'h4);
        check(acc, 21'h80);
        cyc(2);
        check(pc, 21'h8);
        check(acc, 21'h1);
    endtask

    task automatic jump_test;
        start(4'h0);
        m.prog[0] = 16'hef34;
        m.prog[1] = 16'hfabc;
        m.prog[20'habc34] = 16'hefff; // Jump to top of program space
        m.prog[20'habc35] = 16'hffff;
        m.prog[20'hfffff] = 16'hef12; // Second word missing
        cyc(1);
        check(pc, 21'h2);
        cyc(1);
        check(pc, 21'h157868);
        cyc(2);
        check(pc, 21'h1ffffe);
        cyc(2);
        check(pc, 21'h2);
    endtask

    // Clock at 40 ns
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Hang guard, far beyond the fewer than one hundred cycles needed
    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        bank_select_register = 4'h0;
        toggle_test();
        inc_test();
        branch_test();
        jump_test();
        give_verdict();
    end
endmodule
`default_nettype wire
